// ===== hdl/blsr_consts.svh
/*
 * constants for the bridge lock and system-error block: register map,
 * field positions, reset values and timing figures.
 * assumes inclusion by every file that decodes registers or fields.
 */
//
// Behaviour
// - no syserr output unless command enable set
// - every syserr assertion sets signaled-syserr status
// - forward secondary syserr when forward enable set
// - posted write aborts, master timeout raise syserr
// - discard after retry limit, raise syserr
// - reason register, per-event disables, timeout enable
// - only downstream locks; upstream passes unlocked
// - existing lock or busy target: retry
// - only memory read opens lock, else abort
// - locked writes posted, locked reads not prefetched
// - after locked read queued, retry crossing traffic
// - earlier queued work drains before locked read
// - lock deasserted address phase, asserted next cycle; the code asserts it two cycles after the address phase
// - lock held after target then primary data
// - master timeout discards read, releases lock
// - later locked transactions driven locked downstream
// - aborted locked read returns status, no lock
// - retry releases lock only on opening transaction
// - initiator lock and frame idle: release lock
// - final locked posted write releases lock
// - locked posted write abort raises syserr
`ifndef BLSR_CONSTS_SVH
`define BLSR_CONSTS_SVH
// ********
// register byte offsets
// ********
`define BLSR_OFS_CTRL    8'h00
`define BLSR_OFS_STAT    8'h04
`define BLSR_OFS_REASON  8'h08
`define BLSR_OFS_DISABLE 8'h0c
`define BLSR_OFS_LOCK    8'h10
// control fields
`define BLSR_CTL_SERR_EN  0
`define BLSR_CTL_FWD_EN   1
`define BLSR_CTL_MTO_EN   2
`define BLSR_CTL_MA_MODE  3
`define BLSR_CTL_RST      4'h0
// status fields, write one to clear
`define BLSR_ST_SIG_SERR  0
`define BLSR_ST_RCV_SERR  1
`define BLSR_ST_RCV_TA    2
`define BLSR_ST_RCV_MA    3
// reason and disable field positions
`define BLSR_EV_PW_TA     0
`define BLSR_EV_PW_MA     1
`define BLSR_EV_PW_DISC   2
`define BLSR_EV_DW_DISC   3
`define BLSR_EV_DR_DISC   4
`define BLSR_EV_MTO       5
`define BLSR_EV_SEC_SERR  6
`define BLSR_NEV          7
`define BLSR_DIS_RST      7'h00
// pci memory read command
`define BLSR_CMD_MEMRD    4'h6
// axi responses
`define BLSR_RESP_OKAY    2'h0
`define BLSR_RESP_SLVERR  2'h2
// default retry limit, two to the twenty-fourth
`define BLSR_RETRY_LIMIT  16777216
`endif

// ===== hdl/blsr_pkg.sv
/*
 * types shared by the bridge lock and system-error block.
 * assumes the constants header is included where fields are decoded.
 */
package blsr_pkg;
  // ********
  // transaction carriers
  // ********
  typedef enum logic [1:0] {BLSR_OK, BLSR_RETRY, BLSR_TABORT, BLSR_MABORT} blsr_stat_e;
  typedef enum logic [1:0] {BLSR_PW, BLSR_DW, BLSR_DR} blsr_kind_e;
  typedef enum logic [2:0] {
    BLSR_FWD, BLSR_FWD_LOCKED, BLSR_ANS_RETRY, BLSR_ANS_MA, BLSR_ANS_TA, BLSR_ANS_DATA
  } blsr_ans_e;
  // primary transaction decoded by the target front end
  typedef struct packed {
    logic        valid;
    logic        locked;     // initiator used the lock sequence
    logic        upstream;
    logic        lock_end;   // lock relinquished at end of this write
    logic [3:0]  cmd;
    logic [3:0]  be;
    logic [31:0] addr;
  } blsr_ptxn_s;
  // answer to the primary front end
  typedef struct packed {
    logic      valid;
    blsr_ans_e code;
    logic      no_prefetch;
  } blsr_pans_s;
  // completion of a transaction on the target bus
  typedef struct packed {
    logic       valid;
    logic       lock_rd;     // the locked read itself
    blsr_kind_e kind;
    blsr_stat_e stat;
  } blsr_tdone_s;
endpackage

// ===== hdl/blsr_top.sv
/*
 * bridge lock and system-error logic: carries locked sequences downstream,
 * drives the open-drain primary syserr pin, axi4-lite register slave.
 * assumes the transaction front ends run on aclk; bus pins are resynced.
 */
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "blsr_consts.svh"
module blsr_top #(
  parameter int RETRY_LIMIT = `BLSR_RETRY_LIMIT
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // pins, asynchronous to the logic until resynced
  input  wire logic                downstream_syserr_in_n,
  input  wire logic                pri_lock_in_n,
  input  wire logic                pri_frame_in_n,
  input  wire logic                sec_lock_in_n,
  input  wire logic                sec_frame_in_n,
  input  wire logic                sec_irdy_in_n,
  output logic                     upstream_syserr_out_n,
  output logic                     upstream_syserr_oe,
  output logic                     sec_lock_out_n,
  output logic                     sec_lock_oe,
  // front ends
  input  wire blsr_pkg::blsr_ptxn_s  pri_txn,
  output blsr_pkg::blsr_pans_s       pri_ans,
  input  wire logic                queue_drained,
  output logic                     lock_launch_req,
  input  wire logic                tgt_addr_phase,
  input  wire blsr_pkg::blsr_tdone_s tgt_done,
  input  wire logic                dly_mto,
  input  wire logic                dly_mto_lock,
  output logic                     discard
);
  // ********
  // pin resync, two flops each
  // ********
  localparam int NS = 6;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  wire  [NS-1:0] pins = {downstream_syserr_in_n, pri_lock_in_n, pri_frame_in_n,
                         sec_lock_in_n, sec_frame_in_n, sec_irdy_in_n};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= {NS{1'b1}};
      sync2_reg <= {NS{1'b1}};
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  wire sec_serr_n  = sync2_reg[5];
  wire pri_lock_n  = sync2_reg[4];
  wire pri_frame_n = sync2_reg[3];
  wire sec_lock_n  = sync2_reg[2];
  wire sec_idle    = sync2_reg[1] & sync2_reg[0];

  // ********
  // axi4-lite slave
  // ********
  logic [7:0]  awa_reg;
  logic        awh_reg;
  logic [31:0] wd_reg;
  logic [3:0]  ws_reg;
  logic        wh_reg;
  logic        bv_reg;
  logic [1:0]  br_reg;
  logic        rv_reg;
  logic [31:0] rd_reg;
  logic [1:0]  rr_reg;
  logic [3:0]  ctrl_reg;
  logic [3:0]  stat_reg;
  logic [`BLSR_NEV-1:0] reason_reg;
  logic [`BLSR_NEV-1:0] dis_reg;
  // address and data may arrive in either order; answer when both held
  assign s_axi_awready = !awh_reg;
  assign s_axi_wready  = !wh_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  wire wr_go   = awh_reg & wh_reg & !bv_reg;
  wire wr_ctl  = wr_go & (awa_reg == `BLSR_OFS_CTRL) & ws_reg[0];
  wire wr_st   = wr_go & (awa_reg == `BLSR_OFS_STAT) & ws_reg[0];
  wire wr_rsn  = wr_go & (awa_reg == `BLSR_OFS_REASON) & ws_reg[0];
  wire wr_dis  = wr_go & (awa_reg == `BLSR_OFS_DISABLE) & ws_reg[0];
  wire wr_map  = (awa_reg == `BLSR_OFS_CTRL) | (awa_reg == `BLSR_OFS_STAT)
               | (awa_reg == `BLSR_OFS_REASON) | (awa_reg == `BLSR_OFS_DISABLE)
               | (awa_reg == `BLSR_OFS_LOCK);
  wire rd_go   = s_axi_arvalid & !rv_reg;
  wire [7:0] ra = s_axi_araddr;
  wire rd_map  = (ra == `BLSR_OFS_CTRL) | (ra == `BLSR_OFS_STAT)
               | (ra == `BLSR_OFS_REASON) | (ra == `BLSR_OFS_DISABLE)
               | (ra == `BLSR_OFS_LOCK);
  logic [2:0] lk_code;
  wire [31:0] rd_mux =
      (ra == `BLSR_OFS_CTRL)    ? {28'h0, ctrl_reg}   :
      (ra == `BLSR_OFS_STAT)    ? {28'h0, stat_reg}   :
      (ra == `BLSR_OFS_REASON)  ? {25'h0, reason_reg} :
      (ra == `BLSR_OFS_DISABLE) ? {25'h0, dis_reg}    :
      (ra == `BLSR_OFS_LOCK)    ? {29'h0, lk_code}    : 32'h0;
  // handshake registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_reg <= 1'b0;
      wh_reg  <= 1'b0;
      bv_reg  <= 1'b0;
      rv_reg  <= 1'b0;
      awa_reg <= 8'h0;
      wd_reg  <= 32'h0;
      ws_reg  <= 4'h0;
      br_reg  <= `BLSR_RESP_OKAY;
      rd_reg  <= 32'h0;
      rr_reg  <= `BLSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awh_reg) begin
        awh_reg <= 1'b1;
        awa_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && !wh_reg) begin
        wh_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        bv_reg <= 1'b1;
        br_reg <= wr_map ? `BLSR_RESP_OKAY : `BLSR_RESP_SLVERR;
      end else if (bv_reg && s_axi_bready) begin
        bv_reg  <= 1'b0;
        awh_reg <= 1'b0;
        wh_reg  <= 1'b0;
      end
      if (rd_go) begin
        rv_reg <= 1'b1;
        rd_reg <= rd_mux;
        rr_reg <= rd_map ? `BLSR_RESP_OKAY : `BLSR_RESP_SLVERR;
      end else if (rv_reg && s_axi_rready) begin
        rv_reg <= 1'b0;
      end
    end
  end

  // ********
  // retry limit on the head of the target queue
  // ********
  localparam int RW = $clog2(RETRY_LIMIT + 1);
  localparam logic [RW-1:0] RLIM = RW'(RETRY_LIMIT - 1);
  logic [RW-1:0] rcnt_reg;
  wire t_retry = tgt_done.valid & (tgt_done.stat == blsr_pkg::BLSR_RETRY);
  wire t_limit = t_retry & (rcnt_reg == RLIM);
  assign discard = t_limit;
  // count consecutive retries; any other ending restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rcnt_reg <= '0;
    else if (tgt_done.valid)
      rcnt_reg <= (t_retry && !t_limit) ? rcnt_reg + 1'b1 : '0;
  end

  // ********
  // lock sequencer
  // ********
  typedef enum logic [2:0] {
    LK_IDLE, LK_QUEUED, LK_LAUNCH, LK_RUN, LK_WAIT_REP, LK_ABORT, LK_HELD
  } blsr_lk_e;
  blsr_lk_e    lk_reg;
  blsr_lk_e    lk_next;
  logic [39:0] key_reg;                                   // addr, cmd, be of locked read
  logic        ab_ma_reg;
  logic        drv_reg;
  logic        rel_reg;
  logic        pend_rel_reg;
  logic        hold_reg;
  blsr_pkg::blsr_pans_s ans_reg;
  blsr_pkg::blsr_pans_s ans_next;
  assign lk_code = lk_reg;
  wire pv       = pri_txn.valid;
  wire pcross   = pv & !pri_txn.upstream;
  wire plock    = pcross & pri_txn.locked;
  wire p_match  = plock & ({pri_txn.addr, pri_txn.cmd, pri_txn.be} == key_reg);
  wire p_memrd  = (pri_txn.cmd == `BLSR_CMD_MEMRD);
  wire t_lrd    = tgt_done.valid & tgt_done.lock_rd;
  wire t_pw     = tgt_done.valid & (tgt_done.kind == blsr_pkg::BLSR_PW);
  wire t_abt    = (tgt_done.stat == blsr_pkg::BLSR_TABORT)
                | (tgt_done.stat == blsr_pkg::BLSR_MABORT);
  wire pri_rel  = pri_lock_n & pri_frame_n;
  // default answer outside idle: retry for a downstream request, plain forward for an upstream one
  wire [2:0] plain = pri_txn.upstream ? blsr_pkg::BLSR_FWD : blsr_pkg::BLSR_ANS_RETRY;
  logic rel_now;
  always_comb begin
    lk_next  = lk_reg;
    ans_next = '0;
    rel_now  = 1'b0;
    ans_next.valid = pv;
    ans_next.code  = blsr_pkg::blsr_ans_e'(plain);
    case (lk_reg)
      LK_IDLE: begin
        ans_next.code = blsr_pkg::BLSR_FWD;
        if (plock) begin
          if (!sec_lock_n) begin
            ans_next.code = blsr_pkg::BLSR_ANS_RETRY;
          end else if (!p_memrd) begin
            ans_next.code = blsr_pkg::BLSR_ANS_MA;
          end else begin
            ans_next.code = blsr_pkg::BLSR_ANS_RETRY;
            ans_next.no_prefetch = 1'b1;
            lk_next = LK_QUEUED;
          end
        end
      end
      LK_QUEUED: begin
        // earlier work drains; a foreign lock must clear on an idle bus
        if (queue_drained && sec_lock_n && sec_idle)
          lk_next = LK_LAUNCH;
      end
      LK_LAUNCH: begin
        if (tgt_addr_phase)
          lk_next = LK_RUN;
      end
      LK_RUN: begin
        if (t_lrd) begin
          case (tgt_done.stat)
            blsr_pkg::BLSR_OK: lk_next = LK_WAIT_REP;
            blsr_pkg::BLSR_RETRY: begin
              rel_now = 1'b1;
              lk_next = LK_QUEUED;
            end
            default: begin
              rel_now = 1'b1;
              lk_next = LK_ABORT;
            end
          endcase
        end
      end
      LK_WAIT_REP: begin
        if (p_match) begin
          ans_next.code = blsr_pkg::BLSR_ANS_DATA;
          lk_next = LK_HELD;
        end else if (dly_mto && dly_mto_lock) begin
          rel_now = 1'b1;
          lk_next = LK_IDLE;
        end
      end
      LK_ABORT: begin
        if (p_match) begin
          ans_next.code = ab_ma_reg ? blsr_pkg::BLSR_ANS_MA : blsr_pkg::BLSR_ANS_TA;
          lk_next = LK_IDLE;
        end
      end
      LK_HELD: begin
        if (plock) begin
          ans_next.code = blsr_pkg::BLSR_FWD_LOCKED;
          ans_next.no_prefetch = 1'b1;
        end
        if ((pend_rel_reg && t_pw) || (pri_rel && !pend_rel_reg)) begin
          rel_now = 1'b1;
          lk_next = LK_IDLE;
        end
      end
      default: lk_next = LK_IDLE;
    endcase
  end
  // the locked read asks for the target bus only once it may go
  assign lock_launch_req = (lk_reg == LK_LAUNCH);
  assign pri_ans = ans_reg;
  // sequencer state; outputs of the pin stage are registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lk_reg       <= LK_IDLE;
      ans_reg      <= '0;
      key_reg      <= 40'h0;
      ab_ma_reg    <= 1'b0;
      pend_rel_reg <= 1'b0;
    end else begin
      lk_reg  <= lk_next;
      ans_reg <= ans_next;
      if (lk_reg == LK_IDLE && plock)
        key_reg <= {pri_txn.addr, pri_txn.cmd, pri_txn.be};
      if (t_lrd && t_abt)
        ab_ma_reg <= (tgt_done.stat == blsr_pkg::BLSR_MABORT);
      if (lk_next == LK_IDLE)
        pend_rel_reg <= 1'b0;
      else if (lk_reg == LK_HELD && plock && pri_txn.lock_end)
        pend_rel_reg <= 1'b1;
    end
  end
  // target lock pin: released during the address phase, driven high the clock after
  // and asserted the clock after that; after release it is driven high one clock before letting go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_reg  <= 1'b0;
      rel_reg  <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= (lk_reg == LK_LAUNCH) & tgt_addr_phase;
      drv_reg  <= rel_now ? 1'b0 : (drv_reg | hold_reg);
      rel_reg  <= rel_now;
    end
  end
  assign sec_lock_out_n = !drv_reg;
  assign sec_lock_oe    = drv_reg | hold_reg | rel_reg;

  // ********
  // system error events
  // ********
  // abort on any posted write; master abort needs master abort mode
  wire pw_ta = t_pw & (tgt_done.stat == blsr_pkg::BLSR_TABORT);
  wire pw_ma = t_pw & (tgt_done.stat == blsr_pkg::BLSR_MABORT)
             & ctrl_reg[`BLSR_CTL_MA_MODE];
  wire sserr = !sec_serr_n & ctrl_reg[`BLSR_CTL_FWD_EN];
  logic [`BLSR_NEV-1:0] ev;
  always_comb begin
    ev = '0;
    ev[`BLSR_EV_PW_TA]    = pw_ta;
    ev[`BLSR_EV_PW_MA]    = pw_ma;
    ev[`BLSR_EV_PW_DISC]  = t_limit & (tgt_done.kind == blsr_pkg::BLSR_PW);
    ev[`BLSR_EV_DW_DISC]  = t_limit & (tgt_done.kind == blsr_pkg::BLSR_DW);
    ev[`BLSR_EV_DR_DISC]  = t_limit & (tgt_done.kind == blsr_pkg::BLSR_DR);
    ev[`BLSR_EV_MTO]      = dly_mto & ctrl_reg[`BLSR_CTL_MTO_EN];
    ev[`BLSR_EV_SEC_SERR] = sserr;
  end
  // timeout has its own enable, so its disable bit is ignored
  wire [`BLSR_NEV-1:0] ev_on = ev & ~(dis_reg & ~(`BLSR_NEV'(1) << `BLSR_EV_MTO));
  wire serr_fire = (|ev_on) & ctrl_reg[`BLSR_CTL_SERR_EN];
  logic serr_reg;
  // sticky flags: a new event wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= `BLSR_CTL_RST;
      dis_reg    <= `BLSR_DIS_RST;
      stat_reg   <= 4'h0;
      reason_reg <= '0;
      serr_reg   <= 1'b0;
    end else begin
      serr_reg <= serr_fire;
      if (wr_ctl)
        ctrl_reg <= wd_reg[3:0];
      if (wr_dis)
        dis_reg <= wd_reg[`BLSR_NEV-1:0];
      reason_reg <= ((wr_rsn ? reason_reg & ~wd_reg[`BLSR_NEV-1:0] : reason_reg)
                    | (serr_fire ? ev_on : '0));
      stat_reg <= (wr_st ? stat_reg & ~wd_reg[3:0] : stat_reg);
      if (serr_fire)
        stat_reg[`BLSR_ST_SIG_SERR] <= 1'b1;
      if (sserr)
        stat_reg[`BLSR_ST_RCV_SERR] <= 1'b1;
      if (t_lrd && tgt_done.stat == blsr_pkg::BLSR_TABORT)
        stat_reg[`BLSR_ST_RCV_TA] <= 1'b1;
      if (t_lrd && tgt_done.stat == blsr_pkg::BLSR_MABORT)
        stat_reg[`BLSR_ST_RCV_MA] <= 1'b1;
    end
  end
  // open drain: drive low for one clock per reported event
  assign upstream_syserr_out_n = !serr_reg;
  assign upstream_syserr_oe    = serr_reg;
endmodule // blsr_top

// ===== tb/blsr_partner.sv
/* far side model: secondary bus and the target of the locked read.
   assumes one locked read at a time is launched by the block. */
`timescale 1ns/1ns
module blsr_partner (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             lock_launch_req,
  input  wire logic             sec_lock_out_n,
  input  wire logic             sec_lock_oe,
  input  wire logic             other_lock,
  output logic                  tgt_addr_phase,
  output blsr_pkg::blsr_tdone_s tgt_done,
  output logic                  sec_lock_in_n,
  output logic                  sec_frame_in_n,
  output logic                  sec_irdy_in_n
);
  logic [2:0] cnt_reg;
  // wired lock with pull-up; another master may hold it low
  assign sec_lock_in_n  = (sec_lock_oe ? sec_lock_out_n : 1'b1) & ~other_lock;
  // bus busy from address phase to end of data
  assign sec_frame_in_n = (cnt_reg == 3'h0);
  assign sec_irdy_in_n  = sec_frame_in_n;
  assign tgt_addr_phase = (cnt_reg == 3'h5);
  // all fields idle outside the completion cycle, the bench ors its own in
  assign tgt_done       = (cnt_reg == 3'h1) ?
                          '{1'b1, 1'b1, blsr_pkg::BLSR_DR, blsr_pkg::BLSR_OK} : '0;
  // start only while nobody else holds the lock
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_reg <= 3'h0;
    else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
    else if (lock_launch_req && sec_lock_in_n) cnt_reg <= 3'h5;
  end
endmodule // blsr_partner

// ===== tb/blsr_properties.sv
/* concurrent checks on the lock and syserr block.
   sees only the top ports; bound from the bench top file. */
`timescale 1ns/1ns
`include "blsr_consts.svh"
module blsr_props_chk (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [7:0]            s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  downstream_syserr_in_n,
  input wire logic                  pri_lock_in_n,
  input wire logic                  pri_frame_in_n,
  input wire logic                  upstream_syserr_out_n,
  input wire logic                  sec_lock_out_n,
  input wire logic                  sec_lock_oe,
  input wire blsr_pkg::blsr_ptxn_s  pri_txn,
  input wire blsr_pkg::blsr_pans_s  pri_ans,
  input wire logic                  queue_drained,
  input wire logic                  lock_launch_req,
  input wire logic                  tgt_addr_phase,
  input wire blsr_pkg::blsr_tdone_s tgt_done,
  input wire logic                  discard
);
  // ********
  // enable mirror
  // ********
  logic [1:0] ctl_q;
  // only valid while address and data are offered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= 2'h0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                 s_axi_awaddr == `BLSR_OFS_CTRL && s_axi_wstrb[0]) begin
      ctl_q <= s_axi_wdata[1:0];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********
  // properties
  // ********
  a_serr_needs_en: assert property (!upstream_syserr_out_n |-> ctl_q[0])
    else $error("syserr driven while disabled");
  a_sec_serr_fwd: assert property ($fell(downstream_syserr_in_n) && ctl_q == 2'h3
    |-> ##[1:5] !upstream_syserr_out_n) else $error("secondary syserr not forwarded");
  a_lock_addr_high: assert property (tgt_addr_phase |=> sec_lock_oe && sec_lock_out_n
    ##1 sec_lock_oe && !sec_lock_out_n) else $error("lock sequence wrong on target bus");
  a_answer_next: assert property (pri_txn.valid |=> pri_ans.valid)
    else $error("primary answer missing");
  a_upstream_plain: assert property (pri_txn.valid && pri_txn.upstream
    |=> pri_ans.code == blsr_pkg::BLSR_FWD) else $error("upstream not plain forward");
  a_launch_drained: assert property ($rose(lock_launch_req) |-> $past(queue_drained))
    else $error("locked read launched before queue drained");
  a_discard_retry: assert property (discard
    |-> tgt_done.valid && tgt_done.stat == blsr_pkg::BLSR_RETRY) else $error("bad discard");
  a_locked_noprf: assert property (pri_ans.valid && pri_ans.code == blsr_pkg::BLSR_FWD_LOCKED
    |-> pri_ans.no_prefetch) else $error("locked read prefetched");
  a_release_lock: assert property ($rose(pri_lock_in_n) && pri_frame_in_n && sec_lock_oe
    |-> ##[1:6] sec_lock_out_n) else $error("target lock not released");
endmodule // blsr_props_chk

// ===== tb/test_bridge_lock_and_syserr.sv
/* bench for the lock and syserr block: axi register access, syserr
   events, a full locked sequence. assumes the partner model beside it. */
`timescale 1ns/1ns
`include "blsr_consts.svh"
module test_bridge_lock_and_syserr;
  localparam int LIM = 4; // short retry limit keeps the run brief
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic downstream_syserr_in_n = 1'b1, pri_lock_in_n = 1'b1, pri_frame_in_n = 1'b1;
  logic queue_drained = 1'b0, other_lock = 1'b0, dly_mto = 1'b0, dly_mto_lock = 1'b0;
  logic sec_lock_in_n, sec_frame_in_n, sec_irdy_in_n, upstream_syserr_out_n;
  logic upstream_syserr_oe, sec_lock_out_n, sec_lock_oe, lock_launch_req;
  logic tgt_addr_phase, discard;
  blsr_pkg::blsr_ptxn_s  pri_txn = '0;
  blsr_pkg::blsr_pans_s  pri_ans;
  blsr_pkg::blsr_tdone_s p_done, tgt_done, b_done = '0;
  int n_errors = 0, comparisons = 0, n_serr = 0, n_disc = 0, s0 = 0, i;
  logic [3:0] mc [5] = '{4'h2, 4'h3, 4'h7, 4'ha, 4'hb}; // io, memory write, config
  assign tgt_done = blsr_pkg::blsr_tdone_s'(p_done | b_done);
  blsr_top #(.RETRY_LIMIT(LIM)) dut (.*);
  blsr_partner partner (.*, .tgt_done(p_done));
  always #25 aclk = ~aclk;
  // event counters; syserr is a one-cycle pulse per event
  always @(posedge aclk) begin
    if (upstream_syserr_out_n === 1'b0) n_serr <= n_serr + 1;
    if (discard === 1'b1) n_disc <= n_disc + 1;
  end
  // ********
  // shared tasks
  // ********
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 40) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    lim(i);
    chk(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    lim(i);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask
  // answer is judged in the cycle it stands
  task automatic txn(input logic l, input logic u, input logic [3:0] c,
                     input blsr_pkg::blsr_ans_e code);
    pri_txn <= '{1'b1, l, u, 1'b0, c, 4'hf, 32'h0000_1000};
    @(posedge aclk);
    pri_txn.valid <= 1'b0;
    @(posedge aclk);
    chk({pri_ans.valid, pri_ans.code}, {1'b1, code});
  endtask
  task automatic done(input blsr_pkg::blsr_kind_e k, input blsr_pkg::blsr_stat_e s);
    b_done <= '{1'b1, 1'b0, k, s};
    @(posedge aclk);
    b_done <= '0;
    @(posedge aclk);
  endtask
  // two sync flops plus the registered pin fit well inside eight cycles
  task automatic serr_is(input int e);
    tick(8);
    chk(n_serr - s0, e);
    s0 = n_serr;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_serr;
    rd(8'h14, 32'h0, `BLSR_RESP_SLVERR);
    wr(8'h14, 32'h1, `BLSR_RESP_SLVERR);
    rd(`BLSR_OFS_CTRL, {28'h0, `BLSR_CTL_RST}, `BLSR_RESP_OKAY);
    wr(`BLSR_OFS_CTRL, 32'h2, `BLSR_RESP_OKAY);
    downstream_syserr_in_n <= 1'b0;
    tick(1);
    downstream_syserr_in_n <= 1'b1;
    serr_is(0);
    wr(`BLSR_OFS_STAT, 32'hf, `BLSR_RESP_OKAY);
    wr(`BLSR_OFS_CTRL, 32'h3, `BLSR_RESP_OKAY);
    downstream_syserr_in_n <= 1'b0;
    tick(1);
    downstream_syserr_in_n <= 1'b1;
    serr_is(1);
    rd(`BLSR_OFS_STAT, 32'h3, `BLSR_RESP_OKAY);
    rd(`BLSR_OFS_REASON, 32'h1 << `BLSR_EV_SEC_SERR, `BLSR_RESP_OKAY);
    wr(`BLSR_OFS_REASON, 32'h7f, `BLSR_RESP_OKAY);
    $display("test serr done");
  endtask
  task automatic t_events;
    done(blsr_pkg::BLSR_PW, blsr_pkg::BLSR_TABORT);
    serr_is(1);
    rd(`BLSR_OFS_REASON, 32'h1 << `BLSR_EV_PW_TA, `BLSR_RESP_OKAY);
    done(blsr_pkg::BLSR_PW, blsr_pkg::BLSR_MABORT);
    serr_is(0);
    wr(`BLSR_OFS_DISABLE, 32'h1 << `BLSR_EV_PW_TA, `BLSR_RESP_OKAY);
    done(blsr_pkg::BLSR_PW, blsr_pkg::BLSR_TABORT);
    serr_is(0);
    wr(`BLSR_OFS_REASON, 32'h7f, `BLSR_RESP_OKAY);
    repeat (LIM) done(blsr_pkg::BLSR_DW, blsr_pkg::BLSR_RETRY);
    chk(n_disc, 1);
    serr_is(1);
    rd(`BLSR_OFS_REASON, 32'h1 << `BLSR_EV_DW_DISC, `BLSR_RESP_OKAY);
    $display("test events done");
  endtask
  task automatic t_lock;
    txn(1'b1, 1'b1, `BLSR_CMD_MEMRD, blsr_pkg::BLSR_FWD);
    other_lock <= 1'b1;
    tick(4);
    txn(1'b1, 1'b0, `BLSR_CMD_MEMRD, blsr_pkg::BLSR_ANS_RETRY);
    rd(`BLSR_OFS_LOCK, 32'h0, `BLSR_RESP_OKAY);
    other_lock <= 1'b0;
    pri_lock_in_n <= 1'b0;
    tick(4);
    foreach (mc[k]) txn(1'b1, 1'b0, mc[k], blsr_pkg::BLSR_ANS_MA);
    txn(1'b1, 1'b0, `BLSR_CMD_MEMRD, blsr_pkg::BLSR_ANS_RETRY);
    chk(pri_ans.no_prefetch, 1'b1);
    txn(1'b0, 1'b0, `BLSR_CMD_MEMRD, blsr_pkg::BLSR_ANS_RETRY);
    chk(lock_launch_req, 1'b0);
    queue_drained <= 1'b1;
    for (i = 0; i < 40 && p_done.valid !== 1'b1; i++) @(posedge aclk);
    lim(i);
    tick(2);
    rd(`BLSR_OFS_LOCK, 32'h4, `BLSR_RESP_OKAY);
    chk(sec_lock_out_n, 1'b0);
    txn(1'b1, 1'b0, `BLSR_CMD_MEMRD, blsr_pkg::BLSR_ANS_DATA);
    txn(1'b1, 1'b0, `BLSR_CMD_MEMRD, blsr_pkg::BLSR_FWD_LOCKED);
    chk(pri_ans.no_prefetch, 1'b1);
    pri_lock_in_n <= 1'b1;
    tick(8);
    chk(sec_lock_oe, 1'b0);
    txn(1'b0, 1'b0, `BLSR_CMD_MEMRD, blsr_pkg::BLSR_FWD);
    $display("test lock done");
  endtask
  initial begin
    tick(4);
    aresetn <= 1'b1;
    tick(1);
    t_serr();
    t_events();
    t_lock();
    conclude();
  end
endmodule // test_bridge_lock_and_syserr
bind blsr_top blsr_props_chk chk (.*);
